// file: hw/lvr_pkg.sv
package lvr_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00; // detector control register
  localparam logic [7:0] OFS_INT_STATUS = 8'h04; // sticky detect flags, read only
  localparam logic [7:0] OFS_INT_CLEAR  = 8'h08; // write one to clear, write only
  localparam logic [7:0] OFS_INT_ENABLE = 8'h0C; // fall/rise interrupt enables
  localparam logic [7:0] OFS_STATE      = 8'h10; // live sequencer state, read only

  // detector_control_register fields
  localparam int unsigned CTRL_DET_EN   = 0; // detector_enable
  localparam int unsigned CTRL_RST_EN   = 1; // undervoltage_reset_enable
  localparam int unsigned CTRL_THR_SEL  = 2; // threshold_select

  // status / clear / enable layout
  localparam int unsigned INT_FALL      = 0; // fall_detect_flag / fall_interrupt_enable
  localparam int unsigned INT_RISE      = 1; // rise_detect_flag / rise_interrupt_enable

  // state register fields
  localparam int unsigned ST_RST_ACTIVE = 0;
  localparam int unsigned ST_BELOW      = 1;
  localparam int unsigned ST_COUNTING   = 2;

  // release delay after supply recovery, in system clock cycles
  localparam int unsigned RELEASE_CYCLES = 131072;
  localparam int unsigned MIN_CNT_W      = 18;

  // sequencer states, gray along standby -> hold -> count
  typedef enum logic [1:0] {
    LVR_STANDBY = 2'b00,
    LVR_HOLD    = 2'b01,
    LVR_COUNT   = 2'b11
  } lvr_state_t;

  typedef struct packed {
    logic det_en;
    logic rst_en;
    logic thr_sel;
  } lvr_ctrl_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } lvr_evt_t;

endpackage : lvr_pkg

// file: hw/lvr_sequencer.sv
// Overview of operation
// - standby, inactive after power-on reset until enabled
// - below threshold: drive reset low, clear prescaler
// - reset state held until released or power-on
// - on recovery count 131072 cycles then release
// - undervoltage reset leaves control bits untouched
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// digital half of the undervoltage reset: sync chain, sticky flags, release prescaler
module lvr_sequencer
  import lvr_pkg::*;
#(
  parameter int unsigned CNT_W       = MIN_CNT_W,
  parameter int unsigned RELEASE_CNT = RELEASE_CYCLES
) (
  input  wire logic              ref_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              below_threshold_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              wr_en_in,
  input  wire logic              rd_en_in,
  output logic [DATA_W-1:0]      rd_data_out,
  output logic                   undervoltage_reset_n_out,
  output logic                   detector_enable_out,
  output logic                   threshold_select_out,
  output logic                   irq_out
);

  // refuse a prescaler too narrow for the release count, checked at elaboration
  if (CNT_W < MIN_CNT_W || RELEASE_CNT < 1 || RELEASE_CNT > (64'h1 << CNT_W)) begin : g_bad_params
    $error("lvr_sequencer: CNT_W too small for RELEASE_CNT");
  end

  // last prescaler value; the release edge comes RELEASE_CNT edges after entering count
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RELEASE_CNT - 1);

  // all block state in one packed word so reset and update stay in one place;
  // ctrl survives the undervoltage reset on purpose, only power-on or a bus write clears it
  typedef struct packed {
    logic              sync1;
    logic              sync2;
    logic              below_d;
    lvr_ctrl_t         ctrl;
    lvr_evt_t          flags;
    lvr_evt_t          ien;
    lvr_state_t        fsm;
    logic [CNT_W-1:0]  cnt;
    logic              rst_n;
    logic [DATA_W-1:0] rdata;
  } lvr_regs_t;

  // registered state and its next value
  lvr_regs_t r;
  lvr_regs_t next_r;

  // combinational helpers, derived only from r and the bus strobes
  logic     wr_ctrl;
  logic     wr_clear;
  logic     wr_ien;
  logic     fall_evt;
  logic     rise_evt;
  lvr_evt_t clr; // per-flag clear strobes from a write of ones

  // register decode; the full 8-bit compare keeps the map free of aliases
  assign wr_ctrl  = wr_en_in && (addr_in == OFS_CTRL);
  assign wr_clear = wr_en_in && (addr_in == OFS_INT_CLEAR);
  assign wr_ien   = wr_en_in && (addr_in == OFS_INT_ENABLE);

  // edge events on the synchronised level, only while the comparator is powered;
  // fall means the supply went below the threshold, rise means it came back
  assign fall_evt = r.ctrl.det_en && r.sync2 && !r.below_d;
  assign rise_evt = r.ctrl.det_en && !r.sync2 && r.below_d;

  // clear strobes, one per flag
  assign clr.fall = wr_clear && wr_data_in[INT_FALL];
  assign clr.rise = wr_clear && wr_data_in[INT_RISE];

  // next-state logic for the whole block
  always_comb begin
    // hold every field unless a branch below says otherwise
    next_r = r;
    // first flop feeds only the second, comparator is asynchronous;
    // the chain costs two edges of latency on every comparator change
    next_r.sync1   = below_threshold_in;
    next_r.sync2   = r.sync1;
    // previous synced level, the reference for the edge events
    next_r.below_d = r.sync2;

    // control bits only see bus writes, never the undervoltage reset
    if (wr_ctrl) begin
      next_r.ctrl.det_en  = wr_data_in[CTRL_DET_EN];
      next_r.ctrl.rst_en  = wr_data_in[CTRL_RST_EN];
      next_r.ctrl.thr_sel = wr_data_in[CTRL_THR_SEL];
    end
    // interrupt enables share the bit layout of the status flags
    if (wr_ien) begin
      next_r.ien.fall = wr_data_in[INT_FALL];
      next_r.ien.rise = wr_data_in[INT_RISE];
    end

    // sticky flags: a new event wins over a clear in the same cycle,
    // so a clear that races an edge never loses that edge
    next_r.flags.fall = fall_evt || (r.flags.fall && !clr.fall);
    next_r.flags.rise = rise_evt || (r.flags.rise && !clr.rise);

    // release sequencer:
    // standby -> hold on a dip with both enables set,
    // hold -> count once the supply is back above the threshold,
    // count -> standby after RELEASE_CNT edges, back to hold on a new dip
    case (r.fsm)
      LVR_STANDBY: begin
        // prescaler parked at zero while idle
        next_r.cnt   = '0;
        next_r.rst_n = 1'b1;
        // a powered detector alone only raises flags, it takes both enables to reset
        if (r.ctrl.det_en && r.ctrl.rst_en && r.sync2) begin
          next_r.fsm   = LVR_HOLD;
          next_r.rst_n = 1'b0;
        end
      end
      LVR_HOLD: begin
        // held regardless of enables; only recovery or power-on ends it.
        // limitation: clearing the enables mid-hold does not cut the release short
        // prescaler kept at zero so every count starts clean
        next_r.cnt   = '0;
        next_r.rst_n = 1'b0;
        if (!r.sync2) begin
          next_r.fsm = LVR_COUNT;
        end
      end
      LVR_COUNT: begin
        // reset stays low for the whole window
        next_r.rst_n = 1'b0;
        // a dip mid-count restarts from zero rather than resuming
        if (r.sync2) begin
          next_r.fsm = LVR_HOLD;
          next_r.cnt = '0;
        end else if (r.cnt == CNT_LAST) begin
          // last edge of the window lets the reset go
          next_r.fsm   = LVR_STANDBY;
          next_r.rst_n = 1'b1;
          next_r.cnt   = '0;
        end else begin
          // prescaler advances one per system clock
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      default: begin
        // illegal encodings fall back to standby with the reset released
        next_r.fsm   = LVR_STANDBY;
        next_r.cnt   = '0;
        next_r.rst_n = 1'b1;
      end
    endcase

    // read data stands for the one cycle after the strobe;
    // nothing else loads rdata, so it is back at zero the cycle after
    next_r.rdata = '0;
    if (rd_en_in) begin
      case (addr_in)
        // control bits as last written
        OFS_CTRL: begin
          next_r.rdata[CTRL_DET_EN]  = r.ctrl.det_en;
          next_r.rdata[CTRL_RST_EN]  = r.ctrl.rst_en;
          next_r.rdata[CTRL_THR_SEL] = r.ctrl.thr_sel;
        end
        // sticky flags as the interrupt logic sees them
        OFS_INT_STATUS: begin
          next_r.rdata[INT_FALL] = r.flags.fall;
          next_r.rdata[INT_RISE] = r.flags.rise;
        end
        // interrupt masks
        OFS_INT_ENABLE: begin
          next_r.rdata[INT_FALL] = r.ien.fall;
          next_r.rdata[INT_RISE] = r.ien.rise;
        end
        // live sequencer view for software that polls instead of taking the interrupt
        OFS_STATE: begin
          next_r.rdata[ST_RST_ACTIVE] = !r.rst_n;
          next_r.rdata[ST_BELOW]      = r.sync2;
          next_r.rdata[ST_COUNTING]   = (r.fsm == LVR_COUNT);
        end
        default: begin
          next_r.rdata = '0; // clear register and holes read zero
        end
      endcase
    end
  end

  // single state register; power-on reset puts everything in standby.
  // it is the only reset that clears the control bits, and the internal
  // reset comes out of it released
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r       <= '0;
      r.fsm   <= LVR_STANDBY;
      r.rst_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flops except the level interrupt;
  // rd_data_out stands one cycle only, the master must take it then
  assign rd_data_out              = r.rdata;
  assign undervoltage_reset_n_out = r.rst_n;
  assign detector_enable_out      = r.ctrl.det_en;
  assign threshold_select_out     = r.ctrl.thr_sel;
  // a level, not a pulse: it drops as soon as the flag is cleared or masked
  assign irq_out = (r.flags.fall && r.ien.fall) || (r.flags.rise && r.ien.rise);

endmodule // lvr_sequencer

`default_nettype wire

// file: dv/lvr_comp_model.sv
`timescale 1ns/1ps
`default_nettype none
module lvr_comp_model (
  input  wire logic low_in, // supply dip ordered by the scenario
  input  wire logic pwr_in, // detector_enable from the block
  output logic      below_out
);
  // an unpowered comparator reports nothing, its reference is down
  assign below_out = pwr_in & low_in;
endmodule // lvr_comp_model
`default_nettype wire

// file: dv/lvr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lvr_checker
  import lvr_pkg::*;
#(parameter int unsigned RELEASE_CNT = RELEASE_CYCLES) (
  input wire logic              ref_clk_in,
  input wire logic              reset_n_in,
  input wire logic              below_threshold_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic              wr_en_in,
  input wire logic              undervoltage_reset_n_out,
  input wire logic              detector_enable_out,
  input wire logic              threshold_select_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic        ren_q; // shadow of the reset enable bit
  int unsigned lo_n;  // cycles of recovery seen at the pin, sync delay included
  // shadow and recovery counter; counter restarts on any dip
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ren_q <= 1'b0;
      lo_n  <= 0;
    end else begin
      if (wr_en_in && addr_in == OFS_CTRL) ren_q <= wr_data_in[CTRL_RST_EN];
      lo_n <= (below_threshold_in || undervoltage_reset_n_out) ? 0 : lo_n + 1;
    end
  end
  sequence dip_s; below_threshold_in [*3]; endsequence
  standby_idle_a: assert property (!detector_enable_out && undervoltage_reset_n_out |=> undervoltage_reset_n_out)
    else $error("reset fell while detector off");
  reset_low_a: assert property (dip_s ##0 (detector_enable_out && ren_q && $past(ren_q, 3))
    |-> ##[1:2] !undervoltage_reset_n_out) else $error("no reset on dip");
  hold_low_a: assert property ($fell(undervoltage_reset_n_out) |-> !undervoltage_reset_n_out [*8])
    else $error("reset pulse too short");
  release_cnt_a: assert property ($rose(undervoltage_reset_n_out) |-> lo_n >= RELEASE_CNT && lo_n <= RELEASE_CNT + 6)
    else $error("release count wrong");
  no_early_a: assert property (!undervoltage_reset_n_out && lo_n < RELEASE_CNT |=> !undervoltage_reset_n_out)
    else $error("early release");
  bits_kept_a: assert property (!undervoltage_reset_n_out && !wr_en_in
    |=> $stable(detector_enable_out) && $stable(threshold_select_out)) else $error("control bits lost");
  sync_delay_a: assert property ($rose(below_threshold_in) && undervoltage_reset_n_out
    |=> undervoltage_reset_n_out [*2]) else $error("dip not synchronised");
endmodule // lvr_checker
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lvr_pkg::*;
  localparam int unsigned REL = 16; // short release count keeps the run brief
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              low = 1'b0;
  logic              below;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wd = '0;
  logic              we = 1'b0;
  logic              re = 1'b0;
  logic [DATA_W-1:0] rdat;
  logic              uvr_n, den, tsel, irq;
  int                num_errors = 0;
  int                n_tests = 0;
  int                n;
  // 25 MHz system clock
  always #20 clk = ~clk;
  lvr_sequencer #(.RELEASE_CNT(REL)) dut (.ref_clk_in(clk), .reset_n_in(rst_n), .below_threshold_in(below),
    .addr_in(addr), .wr_data_in(wd), .wr_en_in(we), .rd_en_in(re), .rd_data_out(rdat),
    .undervoltage_reset_n_out(uvr_n), .detector_enable_out(den), .threshold_select_out(tsel), .irq_out(irq));
  lvr_comp_model u_comp (.low_in(low), .pwr_in(den), .below_out(below));
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    chk(rdat, exp);
  endtask
  // bounded wait for the reset output to reach a level
  task automatic wait_rst(input logic lvl);
    n = 0;
    while (uvr_n !== lvl && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      num_errors++;
      $display("BAD %0t timeout", $time);
      results();
    end
  endtask
  task automatic results();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    rd(OFS_CTRL, '0);
    rd(OFS_STATE, '0);
    chk(32'(uvr_n), 1);
    $display("done reset");
  endtask
  task automatic t_undervolt();
    wr(OFS_CTRL, 1);
    repeat (1250) @(posedge clk);
    wr(OFS_INT_CLEAR, 3);
    wr(OFS_CTRL, 7);
    wr(OFS_INT_ENABLE, 1);
    @(posedge clk);
    low <= 1'b1;
    wait_rst(1'b0);
    chk(32'(n >= 2 && n <= 4), 1);
    rd(OFS_INT_STATUS, 1);
    chk(32'(irq), 1);
    chk(32'({tsel, den}), 32'h3);
    rd(OFS_STATE, 32'h3);
    @(posedge clk);
    low <= 1'b0;
    repeat (4) @(posedge clk);
    rd(OFS_STATE, 32'h5);
    @(posedge clk);
    low <= 1'b1;
    repeat (4) @(posedge clk);
    low <= 1'b0;
    wait_rst(1'b1);
    chk(32'(n >= REL && n <= REL + 5), 1);
    rd(OFS_CTRL, 32'h7);
    rd(OFS_INT_STATUS, 3);
    wr(OFS_INT_CLEAR, 3);
    @(negedge clk);
    chk(32'(irq), 0);
    wr(OFS_INT_ENABLE, 0);
    wr(OFS_CTRL, 1);
    wr(OFS_CTRL, 0);
    rd(8'h20, '0);
    rd(OFS_INT_CLEAR, '0);
    $display("done undervolt");
  endtask
  // reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_undervolt();
    results();
  end
endmodule // tb_top
bind lvr_sequencer lvr_checker #(.RELEASE_CNT(RELEASE_CNT)) u_chk (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
  .below_threshold_in(below_threshold_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
  .undervoltage_reset_n_out(undervoltage_reset_n_out), .detector_enable_out(detector_enable_out),
  .threshold_select_out(threshold_select_out));
`default_nettype wire
